/* latch_cell.sv */
// One triggered value latch: edge detect, enable gate, value hold
`timescale 1ns/1ps
`default_nettype none
`include "tvl_map.svh"
module latch_cell (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic scan,
   input wire logic restart,
   input wire logic retain,
   input wire logic enable_required,
   input wire logic enable,
   input wire logic trigger,
   input wire logic signed [`TVL_VALUE_WIDTH-1:0] value_input,
   output logic signed [`TVL_VALUE_WIDTH-1:0] value_output,
   output logic transfer_confirm,
   output logic fired
);
   tvl_pkg::cell_state_type state_reg;
   tvl_pkg::cell_state_type state_next;
   logic operate;
   logic edge_hit;

   // Gate and edge against the previous scan's trigger
   assign operate = !enable_required || enable;
   assign edge_hit = scan && operate && trigger && !state_reg.trig_prev;

   // Next state; a transfer beats the restart clear
   always_comb begin
      state_next = state_reg;
      state_next.fired = 1'b0;
      if (scan) begin
         state_next.trig_prev = trigger;
         state_next.confirm = trigger && operate;
      end
      if (edge_hit) begin
         state_next.value = value_input;
         state_next.fired = 1'b1;
      end else if (restart && !retain) begin
         state_next.value = `TVL_VALUE_RST;
      end
   end

   // Value is otherwise left alone so the operand keeps it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= '0;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   assign value_output = state_reg.value;
   assign transfer_confirm = state_reg.confirm;
   assign fired = state_reg.fired;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_edge_transfer: assert property (@(posedge pclk) disable iff (!presetn)
      ce && edge_hit |=> value_output == $past(value_input) && fired)
      else $error("edge did not transfer value");
   chk_value_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(ce && edge_hit) && !(ce && restart && !retain) |=> $stable(value_output))
      else $error("value changed without an edge");
   chk_confirm_level: assert property (@(posedge pclk) disable iff (!presetn)
      ce && scan |=> transfer_confirm == $past(trigger && operate))
      else $error("confirm does not follow trigger");
   chk_enable_gate: assert property (@(posedge pclk) disable iff (!presetn)
      ce && scan && enable_required && !enable |=> !fired && !transfer_confirm)
      else $error("disabled block acted");
   chk_enable_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      ce && scan && !enable_required && trigger && !state_reg.trig_prev |=> fired)
      else $error("enable not ignored");
   chk_prev_track: assert property (@(posedge pclk) disable iff (!presetn)
      ce && scan && operate && trigger && state_reg.trig_prev |=> !fired)
      else $error("held trigger retransferred");
   chk_retain_keep: assert property (@(posedge pclk) disable iff (!presetn)
      ce && restart && retain && !edge_hit |=> $stable(value_output))
      else $error("retained value lost on restart");
endmodule // latch_cell
`default_nettype wire

/* scan_program.sv */
// Model of the user program: issues one scan evaluation every fourth clock
`timescale 1ns/1ps
`default_nettype none
module scan_program (
   input wire logic pclk,
   input wire logic presetn,
   output logic scan_strobe
);
   logic [1:0] cnt_reg;
   logic [1:0] cnt_next;
   // Free running scan counter; the program never writes the output operands
   always_comb begin
      cnt_next = cnt_reg + 2'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 2'h0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
   // One-cycle pulse, spacing kept wide so each scan is clearly separate
   assign scan_strobe = (cnt_reg == 2'h3);
endmodule // scan_program
`default_nettype wire

/* triggered_value_latch.sv */
// Bank of triggered value latches with an APB configuration slave
`timescale 1ns/1ps
`default_nettype none
`include "tvl_map.svh"
module triggered_value_latch #(
   parameter int NUM_BLOCKS = `TVL_NUM_BLOCKS
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`TVL_ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scan_strobe,
   input wire logic run_mode,
   input wire logic [NUM_BLOCKS-1:0] trigger,
   input wire logic [NUM_BLOCKS-1:0] enable,
   input wire logic [NUM_BLOCKS*`TVL_VALUE_WIDTH-1:0] value_input,
   output logic [NUM_BLOCKS*`TVL_VALUE_WIDTH-1:0] value_output,
   output logic [NUM_BLOCKS-1:0] transfer_confirm,
   output logic [NUM_BLOCKS-1:0] fired
);
   tvl_pkg::bank_state_type state_reg;
   tvl_pkg::bank_state_type state_next;
   logic [31:0] confirm_word;
   logic [31:0] fired_word;
   logic scan_run;
   logic restart;
   logic access;
   logic finish;

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   // One aligned word per register:
   //   enable required mask, read/write, one bit per block
   //   retentive mask, read/write, one bit per block
   //   confirm status, read only, last scan's confirm bits
   //   fired status, read only, high for one cycle after a transfer
   // Status writes are dropped without an error; unmapped addresses
   // answer with pslverr and zero read data, writes to them are lost
   function automatic logic reg_hit(input logic [`TVL_ADDR_WIDTH-1:0] addr,
                                    input logic [`TVL_ADDR_WIDTH-1:0] offset);
      reg_hit = (addr == offset);
   endfunction

   function automatic logic addr_mapped(input logic [`TVL_ADDR_WIDTH-1:0] addr);
      addr_mapped = reg_hit(addr, `TVL_OFS_ENABLE_REQUIRED) || reg_hit(addr, `TVL_OFS_RETAIN_MASK) ||
                    reg_hit(addr, `TVL_OFS_CONFIRM_STATUS) || reg_hit(addr, `TVL_OFS_FIRED_STATUS);
   endfunction

   // Scans are only evaluated in run; stop freezes each cell's value, confirm and trigger history
   assign scan_run = scan_strobe && run_mode;
   assign restart = run_mode && !state_reg.run_prev;

   // Status words, unused upper bits read as zero
   always_comb begin
      confirm_word = '0;
      fired_word = '0;
      confirm_word[NUM_BLOCKS-1:0] = transfer_confirm;
      fired_word[NUM_BLOCKS-1:0] = fired;
   end

   // ---------------------------------------------------------------
   // APB slave: one wait state, then pready for a single cycle
   // ---------------------------------------------------------------
   // First access-phase cycle, then the cycle that shows pready
   assign access = psel && penable && !state_reg.pready;
   assign finish = psel && penable && state_reg.pready;

   always_comb begin
      state_next = state_reg;
      state_next.run_prev = run_mode;
      state_next.pready = access;
      if (access) begin
         state_next.pslverr = !addr_mapped(paddr);
         state_next.prdata = '0;
         if (!pwrite) begin
            if (reg_hit(paddr, `TVL_OFS_ENABLE_REQUIRED)) begin
               state_next.prdata = state_reg.enable_required;
            end else if (reg_hit(paddr, `TVL_OFS_RETAIN_MASK)) begin
               state_next.prdata = state_reg.retain_mask;
            end else if (reg_hit(paddr, `TVL_OFS_CONFIRM_STATUS)) begin
               state_next.prdata = confirm_word;
            end else if (reg_hit(paddr, `TVL_OFS_FIRED_STATUS)) begin
               state_next.prdata = fired_word;
            end
         end
      end else if (!finish) begin
         state_next.pslverr = 1'b0;
         state_next.prdata = '0;
      end
      // Writes land on the edge that samples pready high
      if (finish && pwrite) begin
         if (reg_hit(paddr, `TVL_OFS_ENABLE_REQUIRED)) begin
            state_next.enable_required = pwdata;
         end
         if (reg_hit(paddr, `TVL_OFS_RETAIN_MASK)) begin
            state_next.retain_mask = pwdata;
         end
      end
   end

   // Retention covers stop to run only: flops cannot keep a value
   // through power loss, so presetn clears every block; a keeper for
   // that case would have to sit outside this bank
   // run_prev resets high so the first run after reset is no restart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg.enable_required <= `TVL_ENABLE_REQUIRED_RST;
         state_reg.retain_mask <= `TVL_RETAIN_MASK_RST;
         state_reg.run_prev <= 1'b1;
         state_reg.pready <= 1'b0;
         state_reg.pslverr <= 1'b0;
         state_reg.prdata <= '0;
      end else if (ce) begin
         state_reg <= state_next;
      end
   end

   assign prdata = state_reg.prdata;
   assign pready = state_reg.pready;
   assign pslverr = state_reg.pslverr;

   // ---------------------------------------------------------------
   // Latch cells
   // ---------------------------------------------------------------
   // Values are signed double words, full two's-complement range
   for (genvar i = 0; i < NUM_BLOCKS; i++) begin : g_cell
      latch_cell u_cell (
         .pclk(pclk),
         .presetn(presetn),
         .ce(ce),
         .scan(scan_run),
         .restart(restart),
         .retain(state_reg.retain_mask[i]),
         .enable_required(state_reg.enable_required[i]),
         .enable(enable[i]),
         .trigger(trigger[i]),
         .value_input(value_input[i*`TVL_VALUE_WIDTH +: `TVL_VALUE_WIDTH]),
         .value_output(value_output[i*`TVL_VALUE_WIDTH +: `TVL_VALUE_WIDTH]),
         .transfer_confirm(transfer_confirm[i]),
         .fired(fired[i])
      );
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   chk_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
      ce && psel && penable && !pready |=> pready ##1 !pready)
      else $error("apb answer not one cycle");
   chk_mask_write: assert property (@(posedge pclk) disable iff (!presetn)
      ce && finish && pwrite && paddr == `TVL_OFS_ENABLE_REQUIRED |=>
      state_reg.enable_required == $past(pwdata))
      else $error("enable mask write lost");
   chk_retain_write: assert property (@(posedge pclk) disable iff (!presetn)
      ce && finish && pwrite && paddr == `TVL_OFS_RETAIN_MASK |=> state_reg.retain_mask == $past(pwdata))
      else $error("retain mask write lost");
   chk_stop_freeze: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !run_mode |=> $stable(value_output))
      else $error("value changed in stop");
   chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      ce && access && !addr_mapped(paddr) |=> pready && pslverr)
      else $error("unmapped access not refused");
   // Register reads and refusals
   chk_mapped_ok: assert property (@(posedge pclk) disable iff (!presetn)
      ce && access && addr_mapped(paddr) |=> pready && !pslverr)
      else $error("mapped access refused");
   chk_read_enable: assert property (@(posedge pclk) disable iff (!presetn)
      ce && access && !pwrite && paddr == `TVL_OFS_ENABLE_REQUIRED |=>
      prdata == $past(state_reg.enable_required))
      else $error("enable mask read wrong");
   chk_read_retain: assert property (@(posedge pclk) disable iff (!presetn)
      ce && access && !pwrite && paddr == `TVL_OFS_RETAIN_MASK |=>
      prdata == $past(state_reg.retain_mask))
      else $error("retain mask read wrong");
   chk_read_confirm: assert property (@(posedge pclk) disable iff (!presetn)
      ce && access && !pwrite && paddr == `TVL_OFS_CONFIRM_STATUS |=>
      prdata == $past(confirm_word))
      else $error("confirm status read wrong");
   chk_read_fired: assert property (@(posedge pclk) disable iff (!presetn)
      ce && access && !pwrite && paddr == `TVL_OFS_FIRED_STATUS |=>
      prdata == $past(fired_word))
      else $error("fired status read wrong");
   chk_status_readonly: assert property (@(posedge pclk) disable iff (!presetn)
      ce && finish && pwrite && (paddr == `TVL_OFS_CONFIRM_STATUS || paddr == `TVL_OFS_FIRED_STATUS) |=>
      $stable(state_reg.enable_required) && $stable(state_reg.retain_mask))
      else $error("status write changed a mask");
   chk_unmapped_write: assert property (@(posedge pclk) disable iff (!presetn)
      ce && finish && pwrite && !addr_mapped(paddr) |=>
      $stable(state_reg.enable_required) && $stable(state_reg.retain_mask))
      else $error("unmapped write changed a mask");
   chk_idle_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !psel |=> !pready && prdata == '0)
      else $error("answer without a request");

   // Scan gating in stop and on restart
   chk_restart_once: assert property (@(posedge pclk) disable iff (!presetn)
      ce && restart |=> !restart)
      else $error("restart held longer than a cycle");
   chk_stop_no_fire: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !run_mode |=> fired == '0 && $stable(transfer_confirm))
      else $error("block acted in stop");
endmodule // triggered_value_latch
`default_nettype wire

/* triggered_value_latch_test.sv */
// Self-checking bench for the triggered value latch bank
`timescale 1ns/1ps
`default_nettype none
`include "tvl_map.svh"
module triggered_value_latch_test;
   localparam int N = 4;
   logic pclk, presetn, ce, psel, penable, pwrite, scan_strobe, run_mode, pready, pslverr, err;
   logic [`TVL_ADDR_WIDTH-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [N-1:0] trigger, enable, transfer_confirm, fired;
   logic [N*32-1:0] vin, vout;
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;
   triggered_value_latch #(.NUM_BLOCKS(N)) i_triggered_value_latch (.pclk(pclk), .presetn(presetn),
      .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .scan_strobe(scan_strobe),
      .run_mode(run_mode), .trigger(trigger), .enable(enable), .value_input(vin),
      .value_output(vout), .transfer_confirm(transfer_confirm), .fired(fired));
   scan_program i_scan_program (.pclk(pclk), .presetn(presetn), .scan_strobe(scan_strobe));
   // ----------------------------------------
   // Clock, timeout and shared tasks
   // ----------------------------------------
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // Ceiling far above the roughly 150 cycles the tests need
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         print_verdict();
      end
   end
   task print_verdict;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s exp %h seen %h", name, exp, seen);
      end
   endtask
   // APB cycle; read data and error are taken at the pready edge only
   task apb_rw(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wait_scan;
      do @(posedge pclk); while (scan_strobe !== 1'b1);
   endtask
   // New inputs land right after one scan, are taken by the next
   task scan(input logic [N-1:0] t, input logic [31:0] v, input logic [N-1:0] ef);
      wait_scan();
      trigger <= t;
      for (int i = 0; i < N; i++) vin[32*i+:32] <= v + 32'(i);
      wait_scan();
      #1;
      check("fired", 32'(fired), 32'(ef));
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {trigger, enable, vin} = '0;
      ce = 1'b1;
      run_mode = 1'b1;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb_rw(1'b0, `TVL_OFS_ENABLE_REQUIRED, 32'h0);
      check("enable_required", rd, `TVL_ENABLE_REQUIRED_RST);
      apb_rw(1'b0, `TVL_OFS_RETAIN_MASK, 32'h0);
      check("retain_mask", rd, `TVL_RETAIN_MASK_RST);
      apb_rw(1'b0, 12'h010, 32'h0);
      check("unmapped err", 32'(err), 32'h1);
      check("unmapped data", rd, 32'h0);
      apb_rw(1'b1, 12'h010, 32'hffff_ffff);
      check("unmapped write err", 32'(err), 32'h1);
      // Edge moves the most negative value, only block 0 fires
      scan(4'b0001, 32'h8000_0000, 4'b0001);
      check("out0", vout[31:0], 32'h8000_0000);
      check("out1", vout[63:32], 32'h0);
      check("confirm", 32'(transfer_confirm), 32'h1);
      // Trigger held high: no second write
      scan(4'b0001, 32'h7fff_ffff, 4'b0000);
      check("out0 held", vout[31:0], 32'h8000_0000);
      check("confirm high", 32'(transfer_confirm), 32'h1);
      apb_rw(1'b0, `TVL_OFS_CONFIRM_STATUS, 32'h0);
      check("confirm status", rd, 32'h1);
      scan(4'b0000, 32'h7fff_ffff, 4'b0000);
      check("out0 kept", vout[31:0], 32'h8000_0000);
      check("confirm low", 32'(transfer_confirm), 32'h0);
      // Gate only block 0; block 1 ignores its low enable
      apb_rw(1'b1, `TVL_OFS_ENABLE_REQUIRED, 32'h1);
      apb_rw(1'b1, `TVL_OFS_CONFIRM_STATUS, 32'hffff_ffff);
      check("status write err", 32'(err), 32'h0);
      apb_rw(1'b0, `TVL_OFS_ENABLE_REQUIRED, 32'h0);
      check("enable_required set", rd, 32'h1);
      scan(4'b0011, 32'h7fff_fffe, 4'b0010);
      check("out0 gated", vout[31:0], 32'h8000_0000);
      check("out1 max", vout[63:32], 32'h7fff_ffff);
      check("confirm gated", 32'(transfer_confirm), 32'h2);
      enable <= 4'b0001;
      scan(4'b0000, 32'h0, 4'b0000);
      scan(4'b0001, 32'h1234_5670, 4'b0001);
      check("out0 enabled", vout[31:0], 32'h1234_5670);
      scan(4'b0000, 32'h0, 4'b0000);
      // Stop and restart: only retentive block 1 keeps its value
      apb_rw(1'b1, `TVL_OFS_RETAIN_MASK, 32'h2);
      @(posedge pclk);
      run_mode <= 1'b0;
      repeat (6) @(posedge pclk);
      run_mode <= 1'b1;
      repeat (3) @(posedge pclk);
      #1;
      check("out0 cleared", vout[31:0], 32'h0);
      check("out1 retained", vout[63:32], 32'h7fff_ffff);
      // Clock enable low: a rising trigger in that scan fires at the next scan after ce returns
      wait_scan();
      ce <= 1'b0;
      trigger <= 4'b1000;
      wait_scan();
      #1;
      check("fired frozen", 32'(fired), 32'h0);
      ce <= 1'b1;
      wait_scan();
      #1;
      check("fired after freeze", 32'(fired), 32'h8);
      check("out3", vout[127:96], 32'h3);
      // Fired status caught in the cycle after the scan that fires block 2
      wait_scan();
      trigger <= 4'b1100;
      repeat (2) @(posedge pclk);
      apb_rw(1'b0, `TVL_OFS_FIRED_STATUS, 32'h0);
      check("fired status", rd, 32'h4);
      check("out2", vout[95:64], 32'h2);
      print_verdict();
   end
endmodule // triggered_value_latch_test
`default_nettype wire

/* tvl_map.svh */
// Register offsets, reset values and sizes for the triggered value latch bank
`ifndef TVL_MAP_SVH
`define TVL_MAP_SVH
// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define TVL_OFS_ENABLE_REQUIRED 12'h000
`define TVL_OFS_RETAIN_MASK 12'h004
`define TVL_OFS_CONFIRM_STATUS 12'h008
`define TVL_OFS_FIRED_STATUS 12'h00c
`define TVL_ADDR_WIDTH 12
// ---------------------------------------------------------------
// Reset values and sizes
// ---------------------------------------------------------------
`define TVL_ENABLE_REQUIRED_RST 32'h0000_0000
`define TVL_RETAIN_MASK_RST 32'h0000_0000
`define TVL_VALUE_RST 32'h0000_0000
`define TVL_NUM_BLOCKS 32
`define TVL_VALUE_WIDTH 32
`endif

/* tvl_pkg.sv */
// State types shared by the latch bank and its cells
`default_nettype none
`include "tvl_map.svh"
package tvl_pkg;
   typedef struct packed {
      logic trig_prev;
      logic signed [`TVL_VALUE_WIDTH-1:0] value;
      logic confirm;
      logic fired;
   } cell_state_type;

   typedef struct packed {
      logic [31:0] enable_required;
      logic [31:0] retain_mask;
      logic run_prev;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } bank_state_type;
endpackage
`default_nettype wire
